// ===== rtl/aosc_bank.sv
// angle output scaling configuration words and output code path
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module aosc_bank
  import aosc_pkg::*;
(
  input  wire logic                      clk_in,          // 25 MHz clock
  input  wire logic                      arst_n_in,       // async reset, low
  input  wire logic                      wr_en_in,        // word write strobe
  input  wire logic                      rd_en_in,        // word read strobe
  input  wire logic [aosc_pkg::ADDR_W-1:0] addr_in,       // word address
  input  wire logic [aosc_pkg::WORD_W-1:0] wdata_in,      // write data
  output logic      [aosc_pkg::WORD_W-1:0] rdata_out,     // read data
  output logic                           rvalid_out,      // read data valid
  input  wire logic [15:0]               angle_in,        // measured angle
  input  wire logic                      angle_valid_in,  // angle strobe
  output logic      [aosc_pkg::CODE_W-1:0] code_out,      // output code
  output logic                           code_valid_out   // code strobe
);
  import aosc_pkg::*;

  // ==========================================================
  // configuration words
  logic [15:0] zero_r,  zero_nxt;    // zero position
  logic [15:0] gainl_r, gainl_nxt;   // range gain low word
  logic [15:0] lolim_r, lolim_nxt;   // lower limit word
  logic [15:0] hilim_r, hilim_nxt;   // upper limit word
  logic [15:0] swgh_r,  swgh_nxt;    // switch angle and gain high
  logic [15:0] ctrl_r,  ctrl_nxt;    // slope control word
  logic [15:0] rdata_nxt;            // next read data
  logic        rvalid_nxt;           // next read valid

  // word writes and read mux
  always_comb begin
    zero_nxt   = zero_r;
    gainl_nxt  = gainl_r;
    lolim_nxt  = lolim_r;
    hilim_nxt  = hilim_r;
    swgh_nxt   = swgh_r;
    ctrl_nxt   = ctrl_r;
    rvalid_nxt = rd_en_in;
    rdata_nxt  = rdata_out;
    if (wr_en_in) begin
      if (addr_in == ADDR_ZERO) begin
        zero_nxt = wdata_in;
      end else if (addr_in == ADDR_GAIN_L) begin
        gainl_nxt = wdata_in;
      end else if (addr_in == ADDR_LO_LIM) begin
        lolim_nxt = wdata_in;
      end else if (addr_in == ADDR_HI_LIM) begin
        hilim_nxt = wdata_in;
      end else if (addr_in == ADDR_SW_GH) begin
        swgh_nxt = wdata_in;
      end else if (addr_in == ADDR_CTRL) begin
        ctrl_nxt = wdata_in;
      end
    end
    if (rd_en_in) begin
      // undefined bits return whatever was stored
      if (addr_in == ADDR_ZERO) begin
        rdata_nxt = zero_r;
      end else if (addr_in == ADDR_GAIN_L) begin
        rdata_nxt = gainl_r;
      end else if (addr_in == ADDR_LO_LIM) begin
        rdata_nxt = lolim_r;
      end else if (addr_in == ADDR_HI_LIM) begin
        rdata_nxt = hilim_r;
      end else if (addr_in == ADDR_SW_GH) begin
        rdata_nxt = swgh_r;
      end else if (addr_in == ADDR_CTRL) begin
        rdata_nxt = ctrl_r;
      end else begin
        rdata_nxt = 16'h0000;                      // unmapped word
      end
    end
  end

  // register the configuration words
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      zero_r     <= RST_ZERO;
      gainl_r    <= RST_GAIN_L;
      lolim_r    <= RST_LO_LIM;
      hilim_r    <= RST_HI_LIM;
      swgh_r     <= RST_SW_GH;
      ctrl_r     <= RST_CTRL;
      rdata_out  <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      zero_r     <= zero_nxt;
      gainl_r    <= gainl_nxt;
      lolim_r    <= lolim_nxt;
      hilim_r    <= hilim_nxt;
      swgh_r     <= swgh_nxt;
      ctrl_r     <= ctrl_nxt;
      rdata_out  <= rdata_nxt;
      rvalid_out <= rvalid_nxt;
    end
  end

  // ==========================================================
  // output code path
  logic [15:0]        corr_w;     // zero corrected angle
  logic [GAIN_W-1:0]  gain_w;     // joined multiplier
  logic [SWANG_W-1:0] swang_w;    // clamp switch angle
  logic [CODE_W-1:0]  lo_w;       // lower limit code
  logic [CODE_W-1:0]  hi_w;       // upper limit code
  logic               falling_w;  // inverted slope
  logic [CODE_W-1:0]  scaled_w;   // clamped code from scaler
  logic [CODE_W-1:0]  code_nxt;   // next output code
  logic               cvalid_nxt; // next code strobe

  // field decode
  always_comb begin
    corr_w    = angle_in - zero_r;
    gain_w    = join_gain(swgh_r, gainl_r);
    swang_w   = swgh_r[WORD_W-1:SWANG_LSB];
    lo_w      = limit_code(lolim_r);
    hi_w      = limit_code(hilim_r);
    falling_w = ctrl_r[SLOPE_BIT];
  end

  aosc_scale u_scale (
    .corr_in    (corr_w),
    .gain_in    (gain_w),
    .swang_in   (swang_w),
    .lo_in      (lo_w),
    .hi_in      (hi_w),
    .falling_in (falling_w),
    .code_out   (scaled_w)
  );

  // hold the code between angle strobes
  always_comb begin
    cvalid_nxt = angle_valid_in;
    code_nxt   = angle_valid_in ? scaled_w : code_out;
  end

  // register the output code
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_out       <= 13'h0000;
      code_valid_out <= 1'b0;
    end else begin
      code_out       <= code_nxt;
      code_valid_out <= cvalid_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // independent reference for the unclamped delta of either slope
  function automatic logic [17:0] ref_delta(input logic [15:0] sw_w, input logic [15:0] gl_w,
                                            input logic [15:0] c_w);
    logic [34:0] p;
    p = 35'({sw_w[5:0], gl_w[15:3]}) * 35'(c_w);
    ref_delta = p[34:17];
  endfunction : ref_delta

  logic [17:0] ref_d; // reference delta
  assign ref_d = ref_delta(swgh_r, gainl_r, corr_w);

  gain_low_wr_a: assert property (wr_en_in && addr_in == ADDR_GAIN_L |=>
    gainl_r == $past(wdata_in)) else $error("low gain word not stored");
  sw_field_wr_a: assert property (wr_en_in && addr_in == ADDR_SW_GH |=>
    swang_w == $past(wdata_in[15:6]) && gain_w[18:13] == $past(wdata_in[5:0]))
    else $error("switch angle or high gain field wrong");
  lower_read_a: assert property (rd_en_in && addr_in == ADDR_LO_LIM && !wr_en_in |=>
    rvalid_out && rdata_out[12:0] == $past(lo_w)) else $error("lower limit readback wrong");
  upper_read_a: assert property (rd_en_in && addr_in == ADDR_HI_LIM && !wr_en_in |=>
    rvalid_out && rdata_out[12:0] == $past(hi_w)) else $error("upper limit readback wrong");
  switch_clamp_a: assert property (angle_valid_in && !falling_w && corr_w[15:6] > swang_w |=>
    code_out == $past(lo_w)) else $error("switch angle did not force lower limit");
  zero_rise_a: assert property (angle_valid_in && !falling_w && corr_w == 16'h0000 &&
    hi_w >= lo_w |=> code_out == $past(lo_w)) else $error("zero angle not at lower limit");
  zero_fall_a: assert property (angle_valid_in && falling_w && corr_w == 16'h0000 &&
    hi_w >= lo_w |=> code_out == $past(hi_w)) else $error("falling slope not at upper limit");
  gain_scale_a: assert property (angle_valid_in && !falling_w && corr_w[15:6] <= swang_w &&
    hi_w >= lo_w && ref_d < 18'(hi_w - lo_w) |=> code_out == $past(lo_w) + $past(ref_d[12:0]))
    else $error("scaled code mismatch");
  code_bounds_a: assert property (angle_valid_in && hi_w >= lo_w ##1 lo_w == $past(lo_w) &&
    hi_w == $past(hi_w) |-> code_out >= lo_w && code_out <= hi_w)
    else $error("code outside limits");
  code_strobe_a: assert property (angle_valid_in |=> code_valid_out ##1
    (code_valid_out || code_out == $past(code_out))) else $error("code strobe or hold wrong");

  // falling slope counts down from the upper limit
  fall_scale_a: assert property (angle_valid_in && falling_w && hi_w >= lo_w &&
    ref_d < 18'(hi_w - lo_w) |=> code_out == $past(hi_w) - $past(ref_d[12:0]))
    else $error("falling scaled code mismatch");

  // readback strobe follows each read request by one cycle
  read_valid_a: assert property (rd_en_in |=> rvalid_out)
    else $error("read strobe not answered");
  read_idle_a: assert property (!rd_en_in |=> !rvalid_out)
    else $error("read valid without a request");

  gain_write_c: cover property (wr_en_in && addr_in == ADDR_GAIN_L ##1 angle_valid_in);
  clamp_switch_c: cover property (angle_valid_in && !falling_w && corr_w[15:6] > swang_w);
  falling_c: cover property (angle_valid_in && falling_w ##1 code_valid_out);
  saturate_c: cover property (angle_valid_in && !falling_w && ref_d >= 18'(hi_w - lo_w));
  // a read answered on the next edge
  read_c: cover property (rd_en_in ##1 rvalid_out);
endmodule : aosc_bank
`default_nettype wire

// ===== rtl/aosc_pkg.sv
// constants for the angle output scaling configuration bank
package aosc_pkg;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_W   = 4;   // word address width
  localparam int unsigned WORD_W   = 16;  // configuration word width
  localparam int unsigned CODE_W   = 13;  // output code width
  localparam int unsigned GAIN_W   = 19;  // joined range gain width
  localparam int unsigned SWANG_W  = 10;  // switch angle width
  // ==========================================================
  // word addresses
  localparam logic [3:0] ADDR_ZERO   = 4'h7; // zero position
  localparam logic [3:0] ADDR_GAIN_L = 4'h9; // range gain low
  localparam logic [3:0] ADDR_LO_LIM = 4'hA; // lower output limit
  localparam logic [3:0] ADDR_HI_LIM = 4'hB; // upper output limit
  localparam logic [3:0] ADDR_SW_GH  = 4'hE; // switch angle and gain high
  localparam logic [3:0] ADDR_CTRL   = 4'hF; // output control word
  // ==========================================================
  // field positions
  localparam int unsigned GAIN_L_LSB = 3;   // low gain fraction starts here
  localparam int unsigned GAIN_H_MSB = 5;   // high gain field top bit
  localparam int unsigned SWANG_LSB  = 6;   // switch angle starts here
  localparam int unsigned SLOPE_BIT  = 8;   // slope direction bit
  localparam int unsigned SCALE_SHR  = 17;  // product to code shift
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [15:0] RST_GAIN_L = 16'h2000;
  localparam logic [15:0] RST_LO_LIM = 16'h0100;
  localparam logic [15:0] RST_HI_LIM = 16'h12FF;
  localparam logic [15:0] RST_SW_GH  = 16'hFFC1;
  localparam logic [15:0] RST_CTRL   = 16'h0C00;

  // extract a 13-bit limit code from a limit word
  function automatic logic [CODE_W-1:0] limit_code(input logic [WORD_W-1:0] w);
    limit_code = w[CODE_W-1:0];
  endfunction : limit_code

  // join high and low range gain into one multiplier
  function automatic logic [GAIN_W-1:0] join_gain(input logic [WORD_W-1:0] hi_w,
                                                 input logic [WORD_W-1:0] lo_w);
    join_gain = {hi_w[GAIN_H_MSB:0], lo_w[WORD_W-1:GAIN_L_LSB]};
  endfunction : join_gain
endpackage : aosc_pkg

// ===== rtl/aosc_scale.sv
// combinational angle to output code scaling and clamping
`timescale 1ns/1ps
`default_nettype none
module aosc_scale
  import aosc_pkg::*;
(
  input  wire logic [15:0]           corr_in,     // zero corrected angle
  input  wire logic [GAIN_W-1:0]     gain_in,     // joined multiplier
  input  wire logic [SWANG_W-1:0]    swang_in,    // clamp switch angle
  input  wire logic [CODE_W-1:0]     lo_in,       // lower output limit
  input  wire logic [CODE_W-1:0]     hi_in,       // upper output limit
  input  wire logic                  falling_in,  // inverted slope
  output logic      [CODE_W-1:0]     code_out     // clamped output code
);
  // ==========================================================
  // datapath
  logic [34:0] prod;   // gain times angle, 2^-17 code units
  logic [17:0] delta;  // code units above the start limit
  logic [17:0] span;   // distance between limits

  // scale, saturate and apply the switch angle
  always_comb begin
    prod  = 35'(gain_in) * 35'(corr_in);
    delta = prod[34:SCALE_SHR];
    span  = (hi_in >= lo_in) ? 18'(hi_in - lo_in) : 18'h00000;
    if (!falling_in && (corr_in[15:SWANG_LSB] > swang_in)) begin
      code_out = lo_in;
    end else if (delta >= span) begin
      code_out = falling_in ? lo_in : hi_in;
    end else if (falling_in) begin
      code_out = hi_in - delta[CODE_W-1:0];
    end else begin
      code_out = lo_in + delta[CODE_W-1:0];
    end
  end
endmodule : aosc_scale
`default_nettype wire

// ===== sim/angle_output_scaling_config_bench.sv
// self-checking bench for the scaling configuration bank
`timescale 1ns/1ps
`default_nettype none
module angle_output_scaling_config_bench;
  import aosc_pkg::*;
  logic        clk = 1'b0;          // 25 MHz clock
  logic        arst_n = 1'b0;       // reset, low
  logic        wr_en, rd_en;        // strobes from model
  logic [3:0]  addr;                // word address
  logic [15:0] wdata, rdata;        // word data
  logic        rvalid, code_valid;  // answer strobes
  logic [15:0] angle = 16'h0000;    // measured angle
  logic        angle_valid = 1'b0;  // angle strobe
  logic [12:0] code;                // output code
  logic [15:0] z, gl, lo, hi, eh, ct; // shadow of stored words
  int          err_count = 0;       // mismatches
  int          checks_done = 0;     // comparisons
  aosc_bank dut (.clk_in(clk), .arst_n_in(arst_n), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
    .angle_in(angle), .angle_valid_in(angle_valid), .code_out(code),
    .code_valid_out(code_valid));
  aosc_prog_model prog (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
  // ==========================================================
  // clock, 40 ns period
  initial forever #20 clk = ~clk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // read through the model, a lost answer ends the run
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit          ok;
    prog.rd(a, d, ok);
    if (!ok) begin
      err_count++;
      summarize();
    end else begin
      chk(d, e);
    end
  endtask : rchk
  // ==========================================================
  // expected code from the shadow words
  function automatic logic [12:0] ex(input logic [15:0] a);
    logic [15:0] c;
    longint      g, d, l, u;
    c = a - z;
    g = {eh[5:0], gl[15:3]};
    d = (g * c) >> 17;
    l = lo[12:0];
    u = hi[12:0];
    if (ct[8] == 1'b0) begin
      if (c[15:6] > eh[15:6]) return 13'(l);
      return 13'((l + d > u) ? u : l + d);
    end
    return 13'((d >= u - l) ? l : u - d);
  endfunction : ex
  task automatic cfg(input logic [15:0] zz, gg, ll, hh, ee, cc);
    {z, gl, lo, hi, eh, ct} = {zz, gg, ll, hh, ee, cc};
    prog.wr(ADDR_ZERO, zz);
    prog.wr(ADDR_GAIN_L, gg);
    prog.wr(ADDR_LO_LIM, ll);
    prog.wr(ADDR_HI_LIM, hh);
    prog.wr(ADDR_SW_GH, ee);
    prog.wr(ADDR_CTRL, cc);
  endtask : cfg
  // four angles on back-to-back strobes
  task automatic stream(input string nm, input logic [15:0] a0, a1, a2, a3);
    logic [15:0] a [4];
    a = '{a0, a1, a2, a3};
    @(posedge clk);
    angle_valid <= 1'b1;
    angle <= a[0];
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (i < 3) angle <= a[i + 1];
      else angle_valid <= 1'b0;
      #1;
      chk(16'(code_valid), 16'h0001);
      chk(16'(code), 16'(ex(a[i])));
    end
    @(posedge clk);
    #1;
    chk(16'(code_valid), 16'h0000);
    $display("test %s done", nm);
  endtask : stream
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rchk(ADDR_ZERO, 16'h0000);
    rchk(ADDR_GAIN_L, 16'h2000);
    rchk(ADDR_LO_LIM, 16'h0100);
    rchk(ADDR_HI_LIM, 16'h12FF);
    rchk(ADDR_SW_GH, 16'hFFC1);
    rchk(ADDR_CTRL, 16'h0C00);
    stream("reset", 16'h0000, 16'h4000, 16'h8000, 16'hFFFF);
  endtask : t_reset
  task automatic t_rdwr;
    prog.wr(ADDR_GAIN_L, 16'hABCF);
    rchk(ADDR_GAIN_L, 16'hABC8);
    prog.wr(ADDR_LO_LIM, 16'h1234);
    rchk(ADDR_LO_LIM, 16'h1234);
    prog.wr(ADDR_LO_LIM, 16'h00FF);
    rchk(ADDR_LO_LIM, 16'h1234);
    prog.wr(ADDR_HI_LIM, 16'h0FED);
    rchk(ADDR_HI_LIM, 16'h0FED);
    prog.wr(ADDR_HI_LIM, 16'h1340);
    rchk(ADDR_HI_LIM, 16'h0FED);
    prog.wr(ADDR_SW_GH, 16'h5A65);
    rchk(ADDR_SW_GH, 16'h5A65);
    prog.wr(4'h3, 16'hBEEF);
    rchk(4'h3, 16'h0000); // unmapped word
    $display("test rdwr done");
  endtask : t_rdwr
  task automatic t_rise;
    cfg(16'h0000, 16'h2000, 16'h0100, 16'h12FF, 16'h8001, 16'h0C00);
    stream("rise", 16'h0000, 16'h4000, 16'h8000, 16'h8040);
  endtask : t_rise
  task automatic t_sat;
    cfg(16'h0000, 16'hFFF8, 16'h0100, 16'h12FF, 16'hFFFF, 16'h0C00);
    stream("sat", 16'h0000, 16'h0010, 16'hFFFF, 16'h0800);
  endtask : t_sat
  task automatic t_fall;
    cfg(16'h0000, 16'h2000, 16'h0100, 16'h12FF, 16'h8001, 16'h0D00);
    stream("fall", 16'h0000, 16'h4000, 16'h8040, 16'hFFFF);
  endtask : t_fall
  task automatic t_zero;
    cfg(16'h4000, 16'h2000, 16'h0200, 16'h1200, 16'hFFC1, 16'h0C00);
    stream("zero", 16'h4000, 16'h3FFF, 16'h8000, 16'h0000);
  endtask : t_zero
  initial begin
    {z, gl, lo, hi, eh, ct} = {16'h0000, 16'h2000, 16'h0100, 16'h12FF, 16'hFFC1, 16'h0C00};
    repeat (20) @(posedge clk);
    chk(16'(code), 16'h0000); // code cleared in reset
    arst_n <= 1'b1;
    t_reset();
    t_rdwr();
    t_rise();
    t_sat();
    t_fall();
    t_zero();
    summarize();
  end
endmodule : angle_output_scaling_config_bench
`default_nettype wire

// ===== sim/aosc_prog_model.sv
// programmer model that writes and reads configuration words
`timescale 1ns/1ps
`default_nettype none
module aosc_prog_model (
  input  wire logic        clk_in,              // bank clock
  input  wire logic [15:0] rdata_in,            // read data
  input  wire logic        rvalid_in,           // read valid
  output var  logic        wr_en_out = 1'b0,    // write strobe
  output var  logic        rd_en_out = 1'b0,    // read strobe
  output var  logic [3:0]  addr_out  = 4'h0,    // word address
  output var  logic [15:0] wdata_out = 16'h0000 // write data
);
  // ==========================================================
  // one word per pulse, undefined bits cleared, reserved codes refused
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = d;
    if (a == 4'h9) m[2:0] = 3'h0;
    if (a == 4'hA || a == 4'hB) m[15:13] = 3'h0;
    if (a == 4'hA && m < 16'h0100) return;
    if (a == 4'hB && m > 16'h1300 && m < 16'h1401) return;
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out  <= a;
    wdata_out <= m;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wdata_out <= ~m; // released data shows no stale value
  endtask : wr
  // ==========================================================
  // read one word, bounded wait for valid
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output bit ok);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out  <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (rvalid_in === 1'b1);
      d = rdata_in;
      if (!ok) @(posedge clk_in);
    end
  endtask : rd
endmodule : aosc_prog_model
`default_nettype wire
